/* File: anps_pkg.sv */
/*
 * Constants for the partner status register pair of the autonegotiation
 * function: management addresses, field positions and reset values.
 * Assumes a 5-bit management register address and 16-bit register data.
 */
// Overview of operation
// - Partner ability register at 0x05, resets zero
// - Bit 15 shows partner next page flag
// - Bit 14 partner acknowledge; software ignores it
// - Bit 13 carries partner remote fault
// - Bit 12 partner extended next page support
// - Seven-bit technology field; 11 asym, 10 sym pause
// - Bits 9..7: T4, TX full, TX half
// - Bit 6 ten full, bit 5 ten half
// - Bits 4..0 partner selector field
// - Expansion register at 0x06, resets 0x0064
// - Page location ability bit reads one always
// - Bit 5 page location reads one always
// - Bit 4 parallel fault latches until read
// - Bit 3 shows partner next page ability
// - Bit 2 local next page ability reads one
// - Bit 1 page received latches until read
// - Bit 0 shows partner negotiation ability
// - Expansion bits 15..7 read zero
package anps_pkg;
   localparam int          ANPS_ADDR_W       = 5;              // Management address width
   localparam int          ANPS_DATA_W       = 16;             // Register width
   localparam logic [4:0]  ANPS_ADDR_ABILITY = 5'h05;          // Partner base page ability
   localparam logic [4:0]  ANPS_ADDR_EXPAND  = 5'h06;          // Expansion status
   localparam logic [15:0] ANPS_ABILITY_RST  = 16'h0000;       // Ability reset value
   localparam logic [15:0] ANPS_EXPAND_RST   = 16'h0064;       // Expansion reset value
   localparam logic [15:0] ANPS_ZERO_WORD    = 16'h0000;       // Unmapped read value
   // Expansion field positions
   localparam int          ANPS_EXP_LOC_ABLE = 6;              // rx_page_location_capable
   localparam int          ANPS_EXP_LOC      = 5;              // rx_page_location
   localparam int          ANPS_EXP_PD_FAULT = 4;              // parallel_detect_fault_latched
   localparam int          ANPS_EXP_LP_PAGES = 3;              // partner_pages_capable
   localparam int          ANPS_EXP_LOC_PGS  = 2;              // local_pages_capable
   localparam int          ANPS_EXP_PAGE_RX  = 1;              // page_received_latched
   localparam int          ANPS_EXP_LP_NEG   = 0;              // partner_negotiation_capable
   // Ability field positions
   localparam int          ANPS_AB_MORE      = 15;             // partner_more_pages_flag
   localparam int          ANPS_AB_ACK       = 14;             // partner_acknowledge
   localparam int          ANPS_AB_RFAULT    = 13;             // partner_remote_fault
   localparam int          ANPS_AB_EXT_PAGES = 12;             // partner_extended_pages_capable
   localparam int          ANPS_AB_ASYM      = 11;             // partner_asym_pause
   localparam int          ANPS_AB_SYM       = 10;             // partner_sym_pause
   localparam int          ANPS_AB_T4        = 9;              // partner_t4_capable
   localparam int          ANPS_AB_TX_FULL   = 8;              // partner_fast_full_duplex
   localparam int          ANPS_AB_TX_HALF   = 7;              // partner_fast_half_duplex
   localparam int          ANPS_AB_TEN_FULL  = 6;              // partner_ten_full_duplex
   localparam int          ANPS_AB_TEN_HALF  = 5;              // partner_ten_half_duplex
   localparam int          ANPS_AB_SEL_HI    = 4;              // Selector field top bit
   localparam int          ANPS_AB_SEL_LO    = 0;              // Selector field bottom bit
   localparam logic        ANPS_FLAG_RST     = 1'b0;           // Latched flag reset value
endpackage : anps_pkg

/* File: anps_latch_high.sv */
/*
 * One latch-high status flag: set by a hardware event, cleared by a
 * management read of its register. Assumes both inputs are one-cycle
 * pulses synchronous to clock.
 */
`timescale 1ns/1ns
module anps_latch_high
   import anps_pkg::*;
(
   input  wire logic clock,     // System clock
   input  wire logic rst_n,     // Asynchronous reset, active low
   input  wire logic set_evt,   // Hardware event
   input  wire logic rd_clear,  // Read of the owning register
   output logic      flag_q     // Latched flag
);
   logic flag_d;                // Next flag value

   // Set wins over clear so an event in the read cycle is kept
   assign flag_d = set_evt | (flag_q & ~rd_clear);

   // Flag register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= ANPS_FLAG_RST;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule : anps_latch_high

/* File: anps_partner_status.sv */
/*
 * Partner base page ability register and autonegotiation expansion
 * status register, read over the management port.
 * Assumes the arbitration logic delivers accepted pages and detection
 * events as one-cycle pulses, and ability levels, all synchronous to
 * clock. Both registers are read-only; there is no write path.
 * A read answers one cycle after its strobe and the word then holds until
 * the next read, so software may pick it up late. Reading the expansion
 * register clears its two latched flags; an event in the same cycle as
 * that read survives it, at the price that the read itself still shows
 * the older value. Other addresses read zero and clear nothing.
 * The acknowledge bit is stored as received although software ignores it.
 */
`timescale 1ns/1ns
module anps_partner_status
   import anps_pkg::*;
(
   input  wire logic        clock,                        // System clock, 10 MHz
   input  wire logic        rst_n,                        // Asynchronous reset, active low
   // Management read port
   input  wire logic        mgmt_rd_en,                   // Read strobe, one cycle
   input  wire logic [4:0]  mgmt_addr,                    // Register address
   output logic [15:0]      mgmt_rd_data_q,               // Read data, registered
   output logic             mgmt_rd_valid_q,              // Read data valid pulse
   // Arbitration side
   input  wire logic        base_page_valid,              // Complete base page accepted
   input  wire logic [15:0] base_page_word,               // Received base link code word
   input  wire logic        next_page_valid,              // Complete next page accepted
   input  wire logic        parallel_detect_fault,        // Parallel detection fault pulse
   input  wire logic        partner_pages_capable,        // Partner can exchange next pages
   input  wire logic        partner_negotiation_capable   // Partner can autonegotiate
);

   // Address decode. Two addresses are mapped; any other one reads zero
   // and has no side effect, so a stray poll of an empty slot can never
   // clear a latched flag. Only the expansion address clears anything.
   wire logic rd_ability;   // Read of partner ability
   wire logic rd_expand;    // Read of expansion status
   wire logic rd_unmapped;  // Any other address

   assign rd_ability  = mgmt_rd_en && (mgmt_addr == ANPS_ADDR_ABILITY);
   assign rd_expand   = mgmt_rd_en && (mgmt_addr == ANPS_ADDR_EXPAND);
   assign rd_unmapped = mgmt_rd_en && !rd_ability && !rd_expand;

   // Partner ability word
   logic [15:0] ability_q;  // Held base page word
   logic [15:0] ability_d;  // Next value

   // Load the whole word at once so a read never sees a mix of pages
   assign ability_d = base_page_valid ? base_page_word : ability_q;

   // Ability register, cleared at reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ability_q <= ANPS_ABILITY_RST;
      end else begin
         ability_q <= ability_d;
      end
   end

   // Named views of the ability fields, handy in waves
   wire logic       partner_more_pages_flag;        // Partner has more pages
   wire logic       partner_acknowledge;            // Handshake only, not for software
   wire logic       partner_remote_fault;           // Partner fault report
   wire logic       partner_extended_pages_capable; // Extended next page support
   wire logic [6:0] partner_tech_field;             // Technology ability field
   wire logic [4:0] partner_selector_field;         // Message space selector

   // Acknowledge is kept as received; software is told to ignore it
   assign partner_more_pages_flag        = ability_q[ANPS_AB_MORE];
   assign partner_acknowledge            = ability_q[ANPS_AB_ACK];
   assign partner_remote_fault           = ability_q[ANPS_AB_RFAULT];
   assign partner_extended_pages_capable = ability_q[ANPS_AB_EXT_PAGES];
   assign partner_selector_field         = ability_q[ANPS_AB_SEL_HI:ANPS_AB_SEL_LO];

   // Technology ability bits, highest first
   wire logic partner_asym_pause;        // Asymmetric pause, full duplex
   wire logic partner_sym_pause;         // Symmetric pause, full duplex
   wire logic partner_t4_capable;        // 100BASE-T4
   wire logic partner_fast_full_duplex;  // 100BASE-TX full duplex
   wire logic partner_fast_half_duplex;  // 100BASE-TX half duplex
   wire logic partner_ten_full_duplex;   // 10BASE-T full duplex
   wire logic partner_ten_half_duplex;   // 10BASE-T half duplex

   assign partner_asym_pause       = ability_q[ANPS_AB_ASYM];
   assign partner_sym_pause        = ability_q[ANPS_AB_SYM];
   assign partner_t4_capable       = ability_q[ANPS_AB_T4];
   assign partner_fast_full_duplex = ability_q[ANPS_AB_TX_FULL];
   assign partner_fast_half_duplex = ability_q[ANPS_AB_TX_HALF];
   assign partner_ten_full_duplex  = ability_q[ANPS_AB_TEN_FULL];
   assign partner_ten_half_duplex  = ability_q[ANPS_AB_TEN_HALF];

   // Seven bits in the order the partner sent them, no reinterpretation
   assign partner_tech_field = {partner_asym_pause, partner_sym_pause,
                                partner_t4_capable, partner_fast_full_duplex,
                                partner_fast_half_duplex, partner_ten_full_duplex,
                                partner_ten_half_duplex};

   // Rebuilt word for reads, one field at a time
   wire logic [15:0] ability_view;
   assign ability_view = {partner_more_pages_flag, partner_acknowledge,
                          partner_remote_fault, partner_extended_pages_capable,
                          partner_tech_field, partner_selector_field};

   // Latched event flags in the expansion register
   wire logic page_event;                   // Any page accepted
   logic      parallel_detect_fault_latched;// Fault seen since last read
   logic      page_received_latched;        // Page seen since last read

   // Base pages and next pages both count as a new page
   assign page_event = base_page_valid | next_page_valid;

   // Fault flag, cleared by reading the expansion register
   anps_latch_high u_fault_flag (
      .clock    (clock),
      .rst_n    (rst_n),
      .set_evt  (parallel_detect_fault),
      .rd_clear (rd_expand),
      .flag_q   (parallel_detect_fault_latched)
   );

   // Page flag, cleared by reading the expansion register
   anps_latch_high u_page_flag (
      .clock    (clock),
      .rst_n    (rst_n),
      .set_evt  (page_event),
      .rd_clear (rd_expand),
      .flag_q   (page_received_latched)
   );

   // Fixed capability bits; next pages have a register of their own,
   // so the location bits never move
   wire logic rx_page_location_capable; // Location bit is meaningful
   wire logic rx_page_location;         // Next pages go to their own register
   wire logic local_pages_capable;      // This end does next pages
   wire logic [8:0] expand_reserved;    // Reserved, read zero

   assign rx_page_location_capable = 1'b1;
   assign rx_page_location         = 1'b1;
   assign local_pages_capable      = 1'b1;
   assign expand_reserved          = 9'h000;

   // Expansion word; with idle levels it equals the reset value.
   // Partner levels are shown live, not latched: they follow the
   // arbitration logic and a read never changes them.
   wire logic [15:0] expand_view;
   assign expand_view = {expand_reserved,
                         rx_page_location_capable,
                         rx_page_location,
                         parallel_detect_fault_latched,
                         partner_pages_capable,
                         local_pages_capable,
                         page_received_latched,
                         partner_negotiation_capable};

   // Read data selection; unmapped addresses answer zero rather than
   // an undefined word, which keeps polling software simple
   wire logic [15:0] rd_mux;
   assign rd_mux = rd_ability ? ability_view :
                   rd_expand  ? expand_view  : ANPS_ZERO_WORD;

   // Read data register: data is held until the next read, so the flags
   // that the read cleared are still visible in the word it returned
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rd_data_q <= ANPS_ZERO_WORD;
      end else if (mgmt_rd_en) begin
         mgmt_rd_data_q <= rd_mux;
      end
   end

   // Valid pulse one cycle after each read strobe; back-to-back strobes
   // give a valid level of the same length
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rd_valid_q <= 1'b0;
      end else begin
         mgmt_rd_valid_q <= mgmt_rd_en;
      end
   end

   // Checks
   // These watch only what the block drives; the arbitration inputs are
   // taken as given. All run on the one clock and are off during reset.
   // Helper: has any base page been loaded since reset; it tells the
   // reset-value check when the register may legally be nonzero
   logic loaded_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         loaded_q <= 1'b0;
      end else if (base_page_valid) begin
         loaded_q <= 1'b1;
      end
   end

   // One clock domain, so one default clocking and reset for all checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Before any page the ability register reads zero
   chk_ability_reset_zero : assert property (
      (rd_ability && !loaded_q) |=> (mgmt_rd_data_q == 16'h0000))
      else $error("ability read not zero before first page");

   // Next page flag reaches a later read from the loaded word
   chk_more_flag_read : assert property (
      (base_page_valid ##1 (rd_ability && !base_page_valid))
      |=> (mgmt_rd_data_q[15] == $past(base_page_word[15], 2)))
      else $error("next page flag read wrong");

   // Lower fields reach a later read unchanged
   chk_ability_fields : assert property (
      (base_page_valid ##1 (rd_ability && !base_page_valid))
      |=> (mgmt_rd_data_q[14:0] == $past(base_page_word[14:0], 2)))
      else $error("ability fields read wrong");

   // Word held steady without a new page
   chk_ability_hold : assert property (
      !base_page_valid |=> $stable(ability_q))
      else $error("ability word changed without page");

   // Fixed bits and reserved bits of expansion
   chk_expand_fixed : assert property (
      rd_expand |=> (mgmt_rd_data_q[15:7] == 9'h000)
                    && mgmt_rd_data_q[6] && mgmt_rd_data_q[5]
                    && mgmt_rd_data_q[2])
      else $error("expansion fixed bits wrong");

   // Fault is reported by the next read, then cleared
   chk_fault_latch : assert property (
      (parallel_detect_fault ##1 (rd_expand && !parallel_detect_fault))
      |=> mgmt_rd_data_q[4] && !parallel_detect_fault_latched)
      else $error("fault flag not latched or not cleared");

   // Page flag survives two cycles without a read
   chk_page_latch : assert property (
      (page_event ##1 (!rd_expand && !page_event)[*2])
      |=> page_received_latched)
      else $error("page flag lost before read");

   // Page event in the read cycle is kept
   chk_page_set_wins : assert property (
      (rd_expand && page_event) |=> page_received_latched)
      else $error("page event lost during read");

   // Partner ability levels seen by the read
   chk_partner_levels : assert property (
      rd_expand |=> (mgmt_rd_data_q[3] == $past(partner_pages_capable))
                    && (mgmt_rd_data_q[0] == $past(partner_negotiation_capable)))
      else $error("partner ability levels read wrong");

   // Unmapped reads answer zero with a valid pulse
   chk_unmapped_zero : assert property (
      rd_unmapped |=> mgmt_rd_valid_q && (mgmt_rd_data_q == 16'h0000))
      else $error("unmapped read not zero");

   // An accepted page lands in the register one edge later, whole
   chk_ability_load : assert property (
      base_page_valid
      |=> (ability_q == $past(base_page_word)))
      else $error("ability word not loaded from page");

   // An ability read returns the stored word in its published order
   chk_ability_read_view : assert property (
      rd_ability
      |=> (mgmt_rd_data_q == $past(ability_q)))
      else $error("ability read differs from stored word");

   // An ability read leaves the page flag alone
   chk_ability_read_keeps : assert property (
      (rd_ability && page_received_latched)
      |=> page_received_latched)
      else $error("ability read cleared page flag");

   // Every read strobe gives a valid pulse
   chk_valid_pulse : assert property (
      mgmt_rd_en
      |=> mgmt_rd_valid_q)
      else $error("read valid missing");

   // No valid pulse without a strobe
   chk_valid_idle : assert property (
      !mgmt_rd_en
      |=> !mgmt_rd_valid_q)
      else $error("read valid without strobe");

   // Read data holds between reads, so slow software can pick it up later
   chk_data_hold : assert property (
      !mgmt_rd_en
      |=> $stable(mgmt_rd_data_q))
      else $error("read data changed without read");

   // Fault flag stays up until the expansion register is read
   chk_fault_hold : assert property (
      (parallel_detect_fault_latched && !rd_expand)
      |=> parallel_detect_fault_latched)
      else $error("fault flag dropped before read");

   // Every fault cycle sets the flag, also during a read
   chk_fault_set_wins : assert property (
      parallel_detect_fault
      |=> parallel_detect_fault_latched)
      else $error("fault event lost");

   // A read with no new fault clears the flag
   chk_fault_clear : assert property (
      (rd_expand && !parallel_detect_fault)
      |=> !parallel_detect_fault_latched)
      else $error("fault flag not cleared by read");

   // Page flag stays up until the expansion register is read
   chk_page_hold : assert property (
      (page_received_latched && !rd_expand)
      |=> page_received_latched)
      else $error("page flag dropped before read");

   // A read with no new page clears the page flag
   chk_page_clear : assert property (
      (rd_expand && !page_event)
      |=> !page_received_latched)
      else $error("page flag not cleared by read");

   // A raised page flag is what the read reports
   chk_page_flag_read : assert property (
      (rd_expand && page_received_latched)
      |=> mgmt_rd_data_q[ANPS_EXP_PAGE_RX])
      else $error("page flag not reported");

   // Both latched flags reach the read as they stood at the strobe
   chk_expand_read_flags : assert property (
      rd_expand
      |=> (mgmt_rd_data_q[ANPS_EXP_PD_FAULT] == $past(parallel_detect_fault_latched))
          && (mgmt_rd_data_q[ANPS_EXP_PAGE_RX] == $past(page_received_latched)))
      else $error("latched flags read wrong");

   // With flags clear and partner levels low the word is the reset value
   chk_expand_idle : assert property (
      (rd_expand && !parallel_detect_fault_latched && !page_received_latched
       && !partner_pages_capable && !partner_negotiation_capable)
      |=> (mgmt_rd_data_q == ANPS_EXPAND_RST))
      else $error("idle expansion word wrong");

   // Scenarios
   cov_page_then_read  : cover property (base_page_valid ##[1:20] rd_ability);
   cov_fault_read      : cover property (parallel_detect_fault ##[1:20] rd_expand);
   cov_read_collision  : cover property (rd_expand && page_event);
   cov_next_page_read  : cover property (next_page_valid ##[1:20] rd_expand);
   cov_fault_next_read : cover property (parallel_detect_fault ##1 rd_expand);

endmodule : anps_partner_status

/* File: anps_partner_model.sv */
/*
 * Remote link partner model: hands accepted pages, fault events and ability
 * levels to the status registers. Assumes the testbench clock and calls.
 */
`timescale 1ns/1ns
module anps_partner_model
   import anps_pkg::*;
(
   input  wire logic   clock,                       // System clock
   output logic        base_page_valid,             // Base page accepted
   output logic [15:0] base_page_word,              // Received code word
   output logic        next_page_valid,             // Next page accepted
   output logic        parallel_detect_fault,       // Fault event
   output logic        partner_pages_capable,       // Partner next page ability
   output logic        partner_negotiation_capable  // Partner negotiation ability
);
   // Idle levels at time zero
   initial begin
      base_page_valid             = 1'b0;
      base_page_word              = 16'h5a5a;
      next_page_valid             = 1'b0;
      parallel_detect_fault       = 1'b0;
      partner_pages_capable       = 1'b0;
      partner_negotiation_capable = 1'b0;
   end
   // Whole word in one cycle; afterwards the word lines are scrambled so a
   // late sample cannot pass for a correct one
   task automatic send_base(input logic [15:0] word);
      @(posedge clock);
      #10;
      base_page_valid = 1'b1;
      base_page_word  = word;
      @(posedge clock);
      #10;
      base_page_valid = 1'b0;
      base_page_word  = ~word;
   endtask : send_base
   // One-cycle next page and fault events
   task automatic pulse(input logic pg, input logic flt);
      @(posedge clock);
      #10;
      next_page_valid       = pg;
      parallel_detect_fault = flt;
      @(posedge clock);
      #10;
      next_page_valid       = 1'b0;
      parallel_detect_fault = 1'b0;
   endtask : pulse
   // Ability levels change between pages
   task automatic set_levels(input logic np, input logic neg);
      @(posedge clock);
      #10;
      partner_pages_capable       = np;
      partner_negotiation_capable = neg;
   endtask : set_levels
endmodule : anps_partner_model

/* File: testbench.sv */
/*
 * Self-checking bench for the partner status registers.
 * Assumes the partner model drives the arbitration side inputs.
 */
`timescale 1ns/1ns
module testbench
   import anps_pkg::*;
();
   logic        clock, rst_n, mgmt_rd_en;          // Clock, reset, read strobe
   logic [4:0]  mgmt_addr;                         // Read address
   logic [15:0] mgmt_rd_data_q, base_page_word, w; // Read data, page word, stimulus
   logic        mgmt_rd_valid_q, base_page_valid;  // Read valid, page valid
   logic        next_page_valid, parallel_detect_fault;
   logic        partner_pages_capable, partner_negotiation_capable;
   logic        exp_pd, exp_pg, exp_np, exp_neg;    // Expected flag and level state
   int          num_errors, n_compared;             // Mismatches, comparisons

   anps_partner_status anps_partner_status_inst (.clock(clock), .rst_n(rst_n),
      .mgmt_rd_en(mgmt_rd_en), .mgmt_addr(mgmt_addr), .mgmt_rd_data_q(mgmt_rd_data_q),
      .mgmt_rd_valid_q(mgmt_rd_valid_q), .base_page_valid(base_page_valid),
      .base_page_word(base_page_word), .next_page_valid(next_page_valid),
      .parallel_detect_fault(parallel_detect_fault),
      .partner_pages_capable(partner_pages_capable),
      .partner_negotiation_capable(partner_negotiation_capable));
   anps_partner_model anps_partner_model_inst (.clock(clock),
      .base_page_valid(base_page_valid), .base_page_word(base_page_word),
      .next_page_valid(next_page_valid), .parallel_detect_fault(parallel_detect_fault),
      .partner_pages_capable(partner_pages_capable),
      .partner_negotiation_capable(partner_negotiation_capable));

   // 10 MHz clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Expected expansion word: fixed ones, latched flags, live levels
   function automatic logic [15:0] exp_expand(input logic pd, input logic pg);
      return {9'h000, 1'b1, 1'b1, pd, exp_np, 1'b1, pg, exp_neg};
   endfunction : exp_expand
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One read; the answer is taken in the cycle after the strobe
   task automatic read_check(input logic [4:0] addr, input logic [15:0] exp);
      @(posedge clock);
      #10;
      mgmt_rd_en = 1'b1;
      mgmt_addr  = addr;
      @(posedge clock);
      #10;
      mgmt_rd_en = 1'b0;
      mgmt_addr  = ~addr;
      check("rd_valid", {15'h0000, mgmt_rd_valid_q}, 16'h0001);
      check("rd_data", mgmt_rd_data_q, exp);
   endtask : read_check
   // Expansion read, which unlatches both flags
   task automatic read_exp();
      read_check(ANPS_ADDR_EXPAND, exp_expand(exp_pd, exp_pg));
      exp_pd = 1'b0;
      exp_pg = 1'b0;
   endtask : read_exp
   task automatic final_report();
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   // Cuts a hang short, well beyond the expected run of a few hundred cycles
   initial begin
      #300000;
      num_errors++;
      final_report();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h6e9b67b3));
      {num_errors, n_compared} = '0;
      {rst_n, mgmt_rd_en, mgmt_addr} = '0;
      {exp_pd, exp_pg, exp_np, exp_neg} = '0;
      repeat (12) @(posedge clock);
      #10 rst_n = 1'b1;
      read_check(ANPS_ADDR_ABILITY, ANPS_ABILITY_RST);
      read_exp();
      // Unmapped addresses read zero
      read_check(5'h00, ANPS_ZERO_WORD);
      read_check(5'h07 + 5'($urandom_range(0, 24)), ANPS_ZERO_WORD);
      // Walking ones, then random words; ability read leaves flags alone
      for (int i = 0; i < 24; i++) begin
         w = (i < 16) ? (16'h0001 << i) : 16'($urandom);
         exp_np  = 1'($urandom_range(0, 1));
         exp_neg = 1'($urandom_range(0, 1));
         anps_partner_model_inst.set_levels(exp_np, exp_neg);
         // Read in the cycle right after the page is taken
         fork
            anps_partner_model_inst.send_base(w);
            begin
               @(posedge clock);
               read_check(ANPS_ADDR_ABILITY, w);
            end
         join
         exp_pg = 1'b1;
         // Optional fault, read in the very next cycle
         exp_pd = 1'($urandom_range(0, 1));
         fork
            if (exp_pd) begin
               anps_partner_model_inst.pulse(1'b0, 1'b1);
            end
            begin
               @(posedge clock);
               read_exp();
            end
         join
         read_exp();
      end
      // Next page alone sets the page flag
      anps_partner_model_inst.pulse(1'b1, 1'b0);
      exp_pg = 1'b1;
      read_exp();
      // Fault and page in the very cycle of a read both survive that read
      fork
         anps_partner_model_inst.pulse(1'b1, 1'b1);
         read_check(ANPS_ADDR_EXPAND, exp_expand(1'b0, 1'b0));
      join
      {exp_pd, exp_pg} = 2'b11;
      read_exp();
      // Reset in mid-run restores both reset values
      anps_partner_model_inst.send_base(16'hbeef);
      anps_partner_model_inst.set_levels(1'b0, 1'b0);
      {exp_np, exp_neg} = 2'b00;
      @(posedge clock);
      #10 rst_n = 1'b0;
      repeat (2) @(posedge clock);
      #10 rst_n = 1'b1;
      read_check(ANPS_ADDR_ABILITY, ANPS_ABILITY_RST);
      read_check(ANPS_ADDR_EXPAND, ANPS_EXPAND_RST);
      final_report();
   end
endmodule : testbench
